// File: hw/fps_pkg.sv
// package for the fault propagation and pwm sync block
package fps_pkg;
  // register offsets and field positions
  localparam logic [7:0] PHASE_CFG_ADDR = 8'h04;
  localparam logic [7:0] PROP_EN_ADDR = 8'h02;
  localparam int INTLV_LSB = 0;
  localparam int INTLV_MSB = 3;
  localparam int RATE_BIT = 5;
  localparam int PHS_LSB = 6;
  localparam int PHS_MSB = 7;
  localparam int PROP_OV_BIT = 1;
  localparam int PROP_UV_BIT = 2;
  localparam int PROP_OC_BIT = 3;
  localparam int PROP_OT_BIT = 4;
  localparam int PROP_TR_BIT = 5;
  localparam logic [5:0] PROP_EN_RESET = 6'h3e;
  localparam logic [3:0] INTLV_RESET = 4'h0;
  // timing
  localparam int CLK_MHZ = 100;
  localparam int HICCUP_MS = 130;
  localparam int HICCUP_CYC = HICCUP_MS * 1000 * CLK_MHZ;
  localparam int SYNC_KHZ = 500;
  localparam int SYNC_PERIOD_CYC = CLK_MHZ * 1000 / SYNC_KHZ;
  localparam int INTLV_STEPS = 16;
  localparam int STEP_CYC_SLOW = SYNC_PERIOD_CYC / INTLV_STEPS;
  localparam int STEP_CYC_FAST = STEP_CYC_SLOW / 2;
  // low pulse length on the health line, in sync periods, per severity
  localparam logic [2:0] PULSE_REGULAR = 3'h1;
  localparam logic [2:0] PULSE_CRITICAL = 3'h2;
  localparam logic [2:0] PULSE_EMERGENCY = 3'h3;

  typedef enum logic [1:0] {OFF_NONE, OFF_REGULAR, OFF_FAST, OFF_EMERGENCY} fps_off_t;

  typedef struct packed {
    logic lowOutput;
    logic excessOutput;
    logic currentLimit;
    logic heatShutdown;
    logic rampFollow;
  } fps_faults_t;

  typedef struct packed {
    logic [1:0] phaseCount;
    logic rateSelect;
    logic [3:0] interleave;
  } fps_phase_t;
endpackage : fps_pkg

// File: hw/fps_health_sync.sv
// three-stage synchroniser with agreement filter
`timescale 1ns/1ns
module fps_health_sync
  import fps_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // async level in, filtered level and edges out
  input wire logic async,
  output logic level,
  output logic rise,
  output logic fall
);
  logic s1_q, s2_q, s3_q;
  logic level_q;
  logic [2:0] fill_q;
  logic primed_q;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      s1_q <= 1'b1;
      s2_q <= 1'b1;
      s3_q <= 1'b1;
    end else begin
      s1_q <= async;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // edges wait until stage three holds a real sample, so a line that is
  // already low when reset lifts does not show a false fall
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      fill_q <= 3'h0;
    end else begin
      fill_q <= {fill_q[1:0], 1'b1};
    end
  end

  // a change counts only once stages two and three agree
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      level_q <= 1'b1;
      primed_q <= 1'b0;
    end else if (fill_q[2] && s2_q == s3_q) begin
      level_q <= s3_q;
      primed_q <= 1'b1;
    end
  end

  assign level = level_q;
  assign rise = primed_q && (s2_q == s3_q) && s3_q && !level_q;
  assign fall = primed_q && (s2_q == s3_q) && !s3_q && level_q;
endmodule : fps_health_sync

// File: hw/fps_fault_prop.sv
// converter fault response, health line propagation and pwm sync
`timescale 1ns/1ns
module fps_fault_prop
  import fps_pkg::*;
#(
  parameter int HICCUP_CYCLES = HICCUP_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // register port
  input wire logic regWrEn,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  output logic [7:0] regRdData,
  // converter status
  input wire fps_faults_t faults,
  input wire logic aboveprebias,
  input wire logic uvLatching,
  input wire logic outputOn,
  input wire logic [1:0] phaseCountIn,
  input wire logic rampDone,
  // external pins
  input wire logic masterSyncLine,
  input wire logic healthIn,
  output logic healthOut,
  output logic healthOe,
  // power stage control
  output logic enableOut,
  output logic sequencedOff,
  output logic fastOff,
  output logic lowSideOn,
  output logic pwmStart,
  output logic [1:0] offType
);
  logic [3:0] intlv_q;
  logic rate_q;
  logic [5:0] propEn_q;
  logic [7:0] rdData_q;
  logic syncFall, hlLvl, hlFall, hlRise;
  fps_off_t localOff, off_q;
  logic localProp;
  logic [2:0] pulseLen_q, pulseCnt_q;
  logic driving_q;
  logic [2:0] rxCnt_q;
  logic rxActive_q;
  logic enable_q, seq_q, fast_q, lowSide_q;
  logic [31:0] hiccup_q;
  logic hiccupRun_q;
  logic [7:0] phaseCnt_q;
  logic phaseArm_q;
  logic pwm_q;
  logic [7:0] lagTarget;

  fps_health_sync u_sync (
    .clk(clk), .rst_b(rst_b), .async(masterSyncLine),
    .level(), .rise(), .fall(syncFall)
  );
  fps_health_sync u_health (
    .clk(clk), .rst_b(rst_b), .async(healthIn),
    .level(hlLvl), .rise(hlRise), .fall(hlFall)
  );

  function automatic logic [2:0] pulse_of(input fps_off_t t);
    case (t)
      OFF_REGULAR: pulse_of = PULSE_REGULAR;
      OFF_FAST: pulse_of = PULSE_CRITICAL;
      OFF_EMERGENCY: pulse_of = PULSE_EMERGENCY;
      default: pulse_of = 3'h0;
    endcase
  endfunction : pulse_of

  // local fault classification and propagation decision
  always_comb begin
    localOff = OFF_NONE;
    localProp = 1'b0;
    if (faults.excessOutput && aboveprebias) begin
      localOff = OFF_FAST;
      localProp = propEn_q[PROP_OV_BIT];
    end else if (faults.currentLimit && aboveprebias) begin
      localOff = OFF_FAST;
      localProp = propEn_q[PROP_OC_BIT];
    end else if (faults.rampFollow) begin
      localOff = OFF_FAST;
      localProp = propEn_q[PROP_TR_BIT];
    end else if (faults.heatShutdown) begin
      localOff = OFF_REGULAR;
      localProp = propEn_q[PROP_OT_BIT];
    end else if (faults.lowOutput) begin
      localOff = OFF_REGULAR;
      localProp = propEn_q[PROP_UV_BIT];
    end
  end

  // register writes
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      intlv_q <= INTLV_RESET;
      rate_q <= 1'b0;
      propEn_q <= PROP_EN_RESET;
    end else if (regWrEn) begin
      if (regAddr == PHASE_CFG_ADDR && !outputOn) begin
        intlv_q <= regWrData[INTLV_MSB:INTLV_LSB];
        rate_q <= regWrData[RATE_BIT];
      end
      if (regAddr == PROP_EN_ADDR) begin
        propEn_q <= {regWrData[PROP_TR_BIT:PROP_OV_BIT], 1'b0};
      end
    end
  end

  // register reads
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rdData_q <= 8'h00;
    end else if (regAddr == PHASE_CFG_ADDR) begin
      rdData_q <= {phaseCountIn, rate_q, 1'b0, intlv_q};
    end else if (regAddr == PROP_EN_ADDR) begin
      rdData_q <= {2'b00, propEn_q};
    end else begin
      rdData_q <= 8'h00;
    end
  end

  // health line transmitter
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      driving_q <= 1'b0;
      pulseLen_q <= 3'h0;
      pulseCnt_q <= 3'h0;
    end else if (!driving_q && localProp && hlLvl && syncFall) begin
      // encode on falling transition, pull low
      driving_q <= 1'b1;
      pulseLen_q <= pulse_of(localOff);
      pulseCnt_q <= 3'h0;
    end else if (driving_q && syncFall) begin
      // hold low for pulse length, then stay low while faulted
      if (pulseCnt_q != pulseLen_q) begin
        pulseCnt_q <= pulseCnt_q + 3'h1;
      end else if (localOff == OFF_NONE) begin
        driving_q <= 1'b0;
      end
    end
  end

  // health line receiver, counts low sync periods
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rxActive_q <= 1'b0;
      rxCnt_q <= 3'h0;
    end else if (hlFall && !driving_q) begin
      rxActive_q <= 1'b1;
      rxCnt_q <= 3'h0;
    end else if (rxActive_q && (hlRise || rxCnt_q == PULSE_EMERGENCY)) begin
      rxActive_q <= 1'b0;
    end else if (rxActive_q && syncFall && !hlLvl) begin
      rxCnt_q <= rxCnt_q + 3'h1;
    end
  end

  // turn-off state
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      off_q <= OFF_NONE;
    end else if (localOff != OFF_NONE) begin
      off_q <= localOff;
    end else if (rxActive_q && (hlRise || rxCnt_q == PULSE_EMERGENCY)) begin
      if (rxCnt_q >= PULSE_EMERGENCY) begin
        off_q <= OFF_EMERGENCY;
      end else if (rxCnt_q >= PULSE_CRITICAL) begin
        off_q <= OFF_FAST;
      end else begin
        off_q <= OFF_REGULAR;
      end
    end else if (hiccupRun_q && hiccup_q == 32'h0) begin
      off_q <= OFF_NONE;
    end
  end

  // power stage control
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      enable_q <= 1'b0;
      seq_q <= 1'b0;
      fast_q <= 1'b0;
      lowSide_q <= 1'b0;
    end else begin
      enable_q <= (off_q == OFF_NONE);
      seq_q <= (off_q == OFF_REGULAR);
      fast_q <= (off_q == OFF_FAST) || (off_q == OFF_EMERGENCY);
      // low side held on only for overvoltage
      lowSide_q <= faults.excessOutput && (off_q == OFF_FAST || off_q == OFF_EMERGENCY);
    end
  end

  // hiccup timer, started at undervoltage fault, independent of delay
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      hiccupRun_q <= 1'b0;
      hiccup_q <= 32'h0;
    end else if (!hiccupRun_q && faults.lowOutput && !uvLatching && rampDone) begin
      hiccupRun_q <= 1'b1;
      hiccup_q <= 32'(HICCUP_CYCLES - 1);
    end else if (hiccupRun_q) begin
      if (hiccup_q == 32'h0) begin
        hiccupRun_q <= 1'b0;
      end else begin
        hiccup_q <= hiccup_q - 32'h1;
      end
    end
  end

  // lag of one step is a sixteenth of the switching period
  assign lagTarget = 8'(rate_q ? intlv_q * STEP_CYC_FAST : intlv_q * STEP_CYC_SLOW);

  // pwm timing from sync falling edge
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      phaseCnt_q <= 8'h00;
      phaseArm_q <= 1'b0;
      pwm_q <= 1'b0;
    end else begin
      pwm_q <= 1'b0;
      if (syncFall) begin
        phaseCnt_q <= 8'h00;
        phaseArm_q <= 1'b1;
      end else if (phaseArm_q) begin
        phaseCnt_q <= phaseCnt_q + 8'h01;
      end
      if (phaseArm_q && phaseCnt_q == lagTarget) begin
        pwm_q <= enable_q;
      // second cycle per sync period at 1 MHz
      end else if (phaseArm_q && rate_q &&
                   phaseCnt_q == 8'(lagTarget + 8'(SYNC_PERIOD_CYC / 2))) begin
        pwm_q <= enable_q;
      end
    end
  end

  assign regRdData = rdData_q;
  assign healthOut = 1'b0;
  assign healthOe = driving_q;
  assign enableOut = enable_q;
  assign sequencedOff = seq_q;
  assign fastOff = fast_q;
  assign lowSideOn = lowSide_q;
  assign pwmStart = pwm_q;
  assign offType = off_q;
endmodule : fps_fault_prop

// File: tb/fps_fault_prop_props.sv
// checker for the fault propagation block ports
`timescale 1ns/1ns
module fps_fault_prop_props
  import fps_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // register and status
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regRdData,
  input wire fps_faults_t faults,
  input wire logic aboveprebias,
  input wire logic rampDone,
  input wire logic [1:0] phaseCountIn,
  // link and power stage
  input wire logic masterSyncLine,
  input wire logic healthOut,
  input wire logic healthOe,
  input wire logic sequencedOff,
  input wire logic fastOff,
  input wire logic lowSideOn,
  input wire logic pwmStart
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // sync was high well before and is low past the synchroniser delay
  sequence s_sync_fall;
    $past(masterSyncLine, 30) && !$past(masterSyncLine, 3);
  endsequence
  sequence s_fast_ls(logic ls);
    fastOff && lowSideOn == ls;
  endsequence
  a_bit4_zero: assert property ($past(regAddr) == PHASE_CFG_ADDR |-> !regRdData[4])
    else $error("bit 4 set");
  a_phase_count: assert property ($past(rst_b) && $past(regAddr) == PHASE_CFG_ADDR |->
    regRdData[7:6] == $past(phaseCountIn)) else $error("phase count wrong");
  a_open_drain: assert property (healthOut == 1'b0)
    else $error("health driven high");
  a_pwm_pulse: assert property (pwmStart |=> (!pwmStart)[*8])
    else $error("pwm start too long");
  a_oe_on_fall: assert property ($rose(healthOe) |-> s_sync_fall)
    else $error("health pulled off sync fall");
  a_ov_fast: assert property ($rose(faults.excessOutput) && aboveprebias |->
    ##[1:20] s_fast_ls(1'b1)) else $error("overvoltage response");
  a_oc_fast: assert property ($rose(faults.currentLimit) && aboveprebias &&
    !faults.excessOutput |-> ##[1:20] s_fast_ls(1'b0)) else $error("overcurrent response");
  a_uv_seq: assert property ($rose(faults.lowOutput) && rampDone && faults == 5'h10 |->
    ##[1:20] sequencedOff && !fastOff) else $error("undervoltage response");
endmodule : fps_fault_prop_props
bind fps_fault_prop fps_fault_prop_props fps_fault_prop_props_i (.clk, .rst_b, .regAddr,
  .regRdData, .faults, .aboveprebias, .rampDone, .phaseCountIn, .masterSyncLine, .healthOut,
  .healthOe, .sequencedOff, .fastOff, .lowSideOn, .pwmStart);

// File: tb/fps_power_mgr.sv
// power manager model: sync source and relayed health pulses
`timescale 1ns/1ns
module fps_power_mgr
  import fps_pkg::*;
(
  // relay request from a linked group, and the block's own pull enable
  input wire logic reqPulse,
  input wire logic [2:0] pulseLen,
  input wire logic dutOe,
  // shared lines
  output logic syncLine,
  output logic healthLine,
  // front end command
  output logic frontEndOff
);
  logic [2:0] cnt = 3'h0;
  logic feOff_q = 1'b0;
  // free running 500 kHz sync, offset from the block clock edges
  initial begin
    syncLine = 1'b1;
    #3;
    forever #1000 syncLine = ~syncLine;
  end
  // relayed type unchanged, low for its length in sync falls
  always @(posedge syncLine) begin
    if (cnt != 3'h0) cnt <= cnt - 3'h1;
    else if (reqPulse) cnt <= pulseLen;
  end
  // pull-up: line is low while any party pulls it
  assign healthLine = !(dutOe || cnt != 3'h0);
  // a group error seen at a sync fall shuts the front end off for good
  always @(negedge syncLine) begin
    if (!healthLine) feOff_q <= 1'b1;
  end
  assign frontEndOff = feOff_q;
endmodule : fps_power_mgr

// File: tb/fps_fault_prop_tb.sv
// self-checking bench for the fault propagation block
`timescale 1ns/1ns
module fps_fault_prop_tb
  import fps_pkg::*;
;
  logic clk = 1'b0;
  logic rst_b, regWrEn, aboveprebias, uvLatching, outputOn, rampDone, reqPulse, oeSeen;
  logic masterSyncLine, healthIn, healthOut, healthOe, enableOut, sequencedOff;
  logic fastOff, lowSideOn, pwmStart, frontEndOff;
  logic [7:0] regAddr, regWrData, regRdData, d;
  logic [1:0] phaseCountIn, offType;
  logic [2:0] pulseLen;
  logic [3:0] code;
  fps_faults_t faults;
  int failures = 0, total_checks = 0, n, lag, base, r, k;

  fps_fault_prop #(.HICCUP_CYCLES(200)) fps_fault_prop_i (.clk, .rst_b, .regWrEn, .regAddr,
    .regWrData, .regRdData, .faults, .aboveprebias, .uvLatching, .outputOn, .phaseCountIn,
    .rampDone, .masterSyncLine, .healthIn, .healthOut, .healthOe, .enableOut, .sequencedOff,
    .fastOff, .lowSideOn, .pwmStart, .offType);
  fps_power_mgr fps_power_mgr_i (.reqPulse, .pulseLen, .dutOe(healthOe),
    .syncLine(masterSyncLine), .healthLine(healthIn), .frontEndOff);

  always #5 clk = ~clk;

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic stop_test();
    $display("checks=%0d failures=%0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : stop_test

  function automatic logic [7:0] phase_exp(input logic [7:0] v);
    return {phaseCountIn, v[5], 1'b0, v[3:0]};
  endfunction : phase_exp

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge clk);
    regAddr = a;
    regWrData = v;
    regWrEn = 1'b1;
    @(negedge clk);
    regWrEn = 1'b0;
  endtask : wr

  task automatic rdchk(input logic [7:0] a, input logic [7:0] v);
    @(negedge clk);
    regAddr = a;
    repeat (2) @(negedge clk);
    check(regRdData, v);
  endtask : rdchk

  task automatic reset_dut();
    faults = '0;
    rst_b = 1'b0;
    repeat (8) @(negedge clk);
    rst_b = 1'b1;
    repeat (2) @(negedge clk);
  endtask : reset_dut

  // long runs are cut short here
  initial begin
    #400000;
    failures++;
    stop_test();
  end

  initial begin
    void'($urandom(64210));
    {regWrEn, regAddr, regWrData, aboveprebias, uvLatching, outputOn, rampDone} = '0;
    {reqPulse, pulseLen} = '0;
    phaseCountIn = 2'($urandom);
    reset_dut();
    check(enableOut, 1'b1);
    rdchk(PHASE_CFG_ADDR, phase_exp(8'h00));
    rdchk(PROP_EN_ADDR, 8'h3e);
    rdchk(8'h10, 8'h00);
    repeat (6) begin
      d = 8'($urandom);
      outputOn = 1'b0;
      wr(PHASE_CFG_ADDR, d);
      rdchk(PHASE_CFG_ADDR, phase_exp(d));
      outputOn = 1'b1;
      wr(PHASE_CFG_ADDR, ~d);
      rdchk(PHASE_CFG_ADDR, phase_exp(d));
      wr(PROP_EN_ADDR, d);
      rdchk(PROP_EN_ADDR, d & 8'h3e);
    end
    // lag difference cancels the synchroniser delay
    outputOn = 1'b0;
    for (r = 0; r < 2; r++) begin
      for (k = 0; k < 2; k++) begin
        code = k ? 4'($urandom_range(15, 1)) : 4'h0;
        wr(PHASE_CFG_ADDR, {2'b00, r[0], 1'b0, code});
        repeat (2) @(negedge masterSyncLine);
        for (lag = 0; pwmStart !== 1'b1 && lag < 300; lag++) @(negedge clk);
        if (k == 0) base = lag;
        else check(lag - base, code * (r ? STEP_CYC_FAST : STEP_CYC_SLOW));
      end
    end
    for (k = 0; k < 2; k++) begin
      reset_dut();
      {outputOn, rampDone} = 2'b11;
      if (k == 0) wr(PROP_EN_ADDR, 8'h3a);
      faults.lowOutput = 1'b1;
      for (n = 0; sequencedOff !== 1'b1 && n < 250; n++) @(negedge clk);
      check(offType, OFF_REGULAR);
      if (k == 0) faults = '0;
      oeSeen = 1'b0;
      for (n = 0; sequencedOff === 1'b1 && n < 400; n++) begin
        oeSeen |= healthOe;
        @(negedge clk);
      end
      check(oeSeen, k);
      check(frontEndOff, k);
      if (k == 0) check(n >= 190 && n <= 215, 1'b1);
    end
    for (k = 0; k < 3; k++) begin
      reset_dut();
      outputOn = 1'b1;
      aboveprebias = (k != 2);
      faults.excessOutput = (k == 0);
      faults.currentLimit = (k != 0);
      repeat (30) @(negedge clk);
      check(fastOff, k != 2);
      check(enableOut, k == 2);
      if (k < 2) check(lowSideOn, k == 0);
    end
    for (k = 1; k < 4; k++) begin
      reset_dut();
      outputOn = 1'b1;
      pulseLen = 3'(k);
      reqPulse = 1'b1;
      @(posedge masterSyncLine);
      @(negedge clk);
      reqPulse = 1'b0;
      repeat (900) @(negedge clk);
      check(offType, k);
    end
    stop_test();
  end
endmodule : fps_fault_prop_tb
